// *** common/rpt_defs.svh ***
// Timing constants and geometry for the RGB panel timing and reset block.
// Assumes a 25 MHz reference clock; counts are derived from printed times.
`ifndef RPT_DEFS_SVH
`define RPT_DEFS_SVH
`define RPT_CLK_MHZ 25
`define RPT_RST_REJECT_US 5
`define RPT_RST_FULL_US 10
`define RPT_RST_REJECT_CYC (`RPT_RST_REJECT_US * `RPT_CLK_MHZ)
`define RPT_RST_FULL_CYC (`RPT_RST_FULL_US * `RPT_CLK_MHZ)
`define RPT_ID_LOAD_MS 5
`define RPT_ID_LOAD_CYC (`RPT_ID_LOAD_MS * 1000 * `RPT_CLK_MHZ)
`define RPT_COMPLETE_MS 120
`define RPT_COMPLETE_CYC (`RPT_COMPLETE_MS * 1000 * `RPT_CLK_MHZ)
`define RPT_SPIKE_CYC 4
`define RPT_ACTIVE_PIXELS 480
`define RPT_ACTIVE_LINES 800
`define RPT_LINE_START_MIN 19
`define RPT_FRAME_START_MIN 4
`endif

// *** common/rpt_pkg.sv ***
// Types shared by the RGB panel timing and reset block.
// Pixel words are 24 bits, one per pixel clock.
package rpt_pkg;
  typedef enum logic [3:0] {
    RPT_IDLE = 4'b0001,
    RPT_PEND = 4'b0010,
    RPT_BLANK = 4'b0100,
    RPT_LOAD = 4'b1000
  } rpt_state_e;
  typedef struct packed {
    logic [9:0] line;
    logic [8:0] col;
    logic [23:0] rgb;
  } rpt_pixel_s;
endpackage

// *** sim/rpt_host_model.sv ***
// Host display controller model driving the RGB pixel stream.
// Assumes frames are started only while the block is idle and awake.
`timescale 1ns/1ps
module rpt_host_model (
  output logic pclk_out,
  output logic fsync_n_out,
  output logic lsync_n_out,
  output logic valid_out,
  output logic [23:0] rgb_out
);
  initial
  begin
    pclk_out = 1'b0;
    fsync_n_out = 1'b1;
    lsync_n_out = 1'b1;
    valid_out = 1'b0;
    rgb_out = 24'h000000;
  end
  // Few active lines to keep runs short; porches at minimum
  // Clock stands still between frames
  // Short frames and slow clock put frame rate above range; kept for run time
  task automatic send_frame(input int lines, input bit extra);
    for (int l = 0; l < lines + 6; l++)
    begin
      fsync_n_out = (l >= 2);
      for (int c = 0; c < 504; c++)
      begin
        lsync_n_out = (c >= 5);
        valid_out = (l >= 4) && (l < lines + 4) && (c >= 19) && (c < 499 + int'(extra));
        rgb_out = valid_out ? 24'($urandom) : ~rgb_out;
        // Slowed so eight reference cycles see each pixel clock period
        #160 pclk_out = 1'b1;
        #160 pclk_out = 1'b0;
      end
    end
    fsync_n_out = 1'b1;
    valid_out = 1'b0;
  endtask
endmodule // rpt_host_model

// *** sim/rpt_top_tb.sv ***
// Self-checking bench for the reset sequencer and RGB input path.
// Assumes shortened reset counts and a 320 ns host pixel clock.
`timescale 1ns/1ps
module rpt_top_tb;
  localparam int ID_CYC = 50;
  localparam int DONE_CYC = 200;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hw_n = 1'b1;
  logic awake = 1'b1;
  logic [7:0] otp = 8'h00;
  logic ready = 1'b0;
  logic stall = 1'b0;
  logic pclk, fs_n, ls_n, valid, blank, busy, cmd_ok, wake_ok, pvalid, ovf;
  logic [23:0] rgb;
  logic [7:0] id;
  rpt_pkg::rpt_pixel_s pix;
  int miscompares = 0;
  int comparisons = 0;
  int cyc, m_line, m_col, m_cnt, n;
  bit m_had, ovf_seen, seen, bl;
  logic [42:0] q[$];
  always #20 ref_clk_in = ~ref_clk_in;
  rpt_top #(.REJECT_CYC(5), .FULL_CYC(10), .ID_LOAD_CYC(ID_CYC), .COMPLETE_CYC(DONE_CYC),
    .SPIKE_CYC(2)) rpt_top_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .hw_reset_n_in(hw_n),
    .awake_in(awake), .otp_id_in(otp), .pixel_clock_in(pclk), .frame_sync_n_in(fs_n),
    .line_sync_n_in(ls_n), .pixel_valid_in(valid), .rgb_in(rgb), .second_id_byte_out(id),
    .blank_out(blank), .busy_out(busy), .cmd_ok_out(cmd_ok), .wake_ok_out(wake_ok),
    .pix_out(pix), .pix_valid_out(pvalid), .pix_ready_in(ready), .overflow_out(ovf));
  rpt_host_model rpt_host_model_i (.pclk_out(pclk), .fsync_n_out(fs_n), .lsync_n_out(ls_n),
    .valid_out(valid), .rgb_out(rgb));
  task automatic check(input string what, input logic [42:0] sv, input logic [42:0] ev);
    comparisons++;
    if (sv !== ev)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, ev, sv);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  // Low pulse with optional two-cycle spike, then 20 high cycles
  // A one-cycle spike would vanish in the pin sampler and test nothing
  task automatic pulse(input int low, input int spike);
    seen = 0;
    for (int i = 0; i < low + 20; i++)
    begin
      hw_n = (i >= low) || (spike != 0 && (i == spike || i == spike + 1));
      step(1);
      if (busy === 1'b1)
        seen = 1;
    end
  endtask
  // Counts cycles from release until the chosen flag rises
  task automatic run_till(input bit wake);
    while ((wake ? wake_ok : cmd_ok) !== 1'b1 && n < 400)
    begin
      if (blank !== 1'b1)
        bl = 1;
      n++;
      step(1);
    end
  endtask
  // Reference model of line and column counting
  always @(negedge fs_n) m_line = 0;
  always @(negedge ls_n)
  begin
    if (m_had)
      m_line++;
    m_had = 0;
    m_col = 0;
  end
  always @(posedge pclk)
    if (valid === 1'b1)
    begin
      if (m_col < 480 && m_line < 800 && m_cnt < 4)
      begin
        q.push_back({m_line[9:0], m_col[8:0], rgb});
        m_cnt++;
      end
      m_col++;
      m_had = 1;
    end
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (ovf === 1'b1)
      ovf_seen = 1;
    if (pvalid === 1'b1 && ready === 1'b1)
    begin
      m_cnt--;
      if (q.size() == 0)
        check("spare pixel", 43'h1, 43'h0);
      else
        check("pixel", pix, q.pop_front());
    end
    #1 ready = !stall && $urandom_range(1);
  end
  initial
  begin
    void'($urandom(8090));
    otp = 8'($urandom);
    fork
      begin
        step(5);
        rstn_in = 1'b1;
        step(4);
        check("busy", busy, 1'b0);
        pulse(3, 0);
        check("short busy", seen, 1'b0);
        pulse(7, 0);
        check("mid busy", seen, 1'b1);
        check("mid id", id, 8'h00);
        check("mid idle", busy, 1'b0);
        pulse(16, 8);
        check("full busy", seen, 1'b1);
        n = 20;
        bl = 0;
        run_till(1'b0);
        check("id", id, otp);
        check("id time", n >= ID_CYC && n <= ID_CYC + 12, 1'b1);
        run_till(1'b1);
        check("done time", n >= DONE_CYC && n <= DONE_CYC + 12, 1'b1);
        check("blanked", bl, 1'b0);
        check("shown", blank, 1'b0);
        awake = 1'b0;
        step(3);
        check("sleep blank", blank, 1'b1);
        awake = 1'b1;
        step(3);
        rpt_host_model_i.send_frame(2, 1'b1);
        check("no overflow", ovf_seen, 1'b0);
        stall = 1'b1;
        rpt_host_model_i.send_frame(2, 1'b0);
        stall = 1'b0;
        step(30);
        check("overflow", ovf_seen, 1'b1);
        check("drained", 43'(q.size()), 43'h0);
        check("empty", pvalid, 1'b0);
      end
      begin
        // Ceiling well above the roughly 65000 cycles the scenarios need
        wait (cyc >= 90000);
        miscompares++;
      end
    join_any
    final_report();
  end
endmodule // rpt_top_tb

// *** src/rpt_fifo.sv ***
// Small synchronous FIFO for pixel words.
// Assumes one clock; full and empty are exact.
`timescale 1ns/1ps
module rpt_fifo #(
  parameter int WIDTH = 43,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  wire full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  wire empty = (wp_reg == rp_reg);
  wire push = wr_valid_in && !full;
  wire pop = rd_ready_in && !empty;
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem_reg[rp_reg[AW-1:0]];
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_reg[wp_reg[AW-1:0]] <= wr_data_in;
  end
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule // rpt_fifo

// *** src/rpt_top.sv ***
// Reset filter, blanking/ID reload sequencer and RGB input windowing.
// Assumes pins arrive asynchronously; pixel clock is sampled, not used as a clock.
`timescale 1ns/1ps
`include "rpt_defs.svh"
module rpt_top #(
  parameter int REJECT_CYC = `RPT_RST_REJECT_CYC,
  parameter int FULL_CYC = `RPT_RST_FULL_CYC,
  parameter int ID_LOAD_CYC = `RPT_ID_LOAD_CYC,
  parameter int COMPLETE_CYC = `RPT_COMPLETE_CYC,
  parameter int SPIKE_CYC = `RPT_SPIKE_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic hw_reset_n_in,
  input wire logic awake_in,
  input wire logic [7:0] otp_id_in,
  input wire logic pixel_clock_in,
  input wire logic frame_sync_n_in,
  input wire logic line_sync_n_in,
  input wire logic pixel_valid_in,
  input wire logic [23:0] rgb_in,
  output logic [7:0] second_id_byte_out,
  output logic blank_out,
  output logic busy_out,
  output logic cmd_ok_out,
  output logic wake_ok_out,
  output rpt_pkg::rpt_pixel_s pix_out,
  output logic pix_valid_out,
  input wire logic pix_ready_in,
  output logic overflow_out
);
  // Three-stage samplers for the reset, pixel clock, sync and valid pins; RGB data gets two stages
  logic [2:0] rst_s_reg;
  logic [2:0] pck_s_reg;
  logic [2:0] fs_s_reg;
  logic [2:0] ls_s_reg;
  logic [2:0] pv_s_reg;
  logic [23:0] rgb_s1_reg;
  logic [23:0] rgb_s2_reg;
  logic rst_lvl_reg;
  logic pck_lvl_reg;
  always_ff @(posedge ref_clk_in)
  begin
    rst_s_reg <= {rst_s_reg[1:0], hw_reset_n_in};
    pck_s_reg <= {pck_s_reg[1:0], pixel_clock_in};
    fs_s_reg <= {fs_s_reg[1:0], frame_sync_n_in};
    ls_s_reg <= {ls_s_reg[1:0], line_sync_n_in};
    pv_s_reg <= {pv_s_reg[1:0], pixel_valid_in};
    rgb_s1_reg <= rgb_in;
    rgb_s2_reg <= rgb_s1_reg;
  end
  wire rst_agree = (rst_s_reg[1] == rst_s_reg[2]);
  wire pck_agree = (pck_s_reg[1] == pck_s_reg[2]);
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      rst_lvl_reg <= 1'b1;
      pck_lvl_reg <= 1'b0;
    end
    else
    begin
      if (rst_agree)
        rst_lvl_reg <= rst_s_reg[2];
      if (pck_agree)
        pck_lvl_reg <= pck_s_reg[2];
    end
  end
  // Reset pulse filter; short highs inside a low pulse are bridged
  logic [31:0] low_cnt_reg;
  logic [31:0] hi_cnt_reg;
  logic [31:0] seq_cnt_reg;
  logic full_reg;
  rpt_pkg::rpt_state_e state_reg;
  rpt_pkg::rpt_state_e state_next;
  wire spike_ok = hi_cnt_reg < 32'(SPIKE_CYC);
  wire low_long = low_cnt_reg >= 32'(FULL_CYC);
  wire low_start = low_cnt_reg >= 32'(REJECT_CYC);
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      low_cnt_reg <= '0;
      hi_cnt_reg <= '0;
    end
    else if (!rst_lvl_reg)
    begin
      hi_cnt_reg <= '0;
      if (!low_long)
        low_cnt_reg <= low_cnt_reg + 1;
    end
    else if (spike_ok && low_cnt_reg != '0)
      hi_cnt_reg <= hi_cnt_reg + 1;
    else
    begin
      low_cnt_reg <= '0;
      hi_cnt_reg <= '0;
    end
  end
  wire released = rst_lvl_reg && !spike_ok;
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      rpt_pkg::RPT_IDLE:
        if (low_start)
          state_next = rpt_pkg::RPT_PEND;
      rpt_pkg::RPT_PEND:
        if (released)
          state_next = full_reg ? rpt_pkg::RPT_BLANK : rpt_pkg::RPT_IDLE;
      rpt_pkg::RPT_BLANK:
        if (seq_cnt_reg >= 32'(ID_LOAD_CYC))
          state_next = rpt_pkg::RPT_LOAD;
      rpt_pkg::RPT_LOAD:
        if (seq_cnt_reg >= 32'(COMPLETE_CYC))
          state_next = rpt_pkg::RPT_IDLE;
    endcase
  end
  // Between 5 and 10us the reset starts; it commits only if it reaches 10us
  logic awake_reg;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= rpt_pkg::RPT_IDLE;
      full_reg <= 1'b0;
      seq_cnt_reg <= '0;
      second_id_byte_out <= 8'h00;
      awake_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == rpt_pkg::RPT_IDLE)
        awake_reg <= awake_in;
      if (state_reg == rpt_pkg::RPT_IDLE)
        full_reg <= 1'b0;
      else if (low_long)
        full_reg <= 1'b1;
      if (state_reg == rpt_pkg::RPT_PEND)
        seq_cnt_reg <= '0;
      else if (state_reg != rpt_pkg::RPT_IDLE)
        seq_cnt_reg <= seq_cnt_reg + 1;
      if (state_reg == rpt_pkg::RPT_BLANK && state_next == rpt_pkg::RPT_LOAD)
        second_id_byte_out <= otp_id_in;
    end
  end
  // Blank from reset start until sequence complete; sleep mode just stays blank
  assign blank_out = (state_reg != rpt_pkg::RPT_IDLE) || !awake_reg;
  assign busy_out = (state_reg != rpt_pkg::RPT_IDLE);
  assign cmd_ok_out = (state_reg == rpt_pkg::RPT_IDLE) ||
    (state_reg == rpt_pkg::RPT_LOAD);
  assign wake_ok_out = (state_reg == rpt_pkg::RPT_IDLE);
  // Pixel front end, sampled on rising pixel clock edges
  logic pck_prev_reg;
  logic fs_reg;
  logic ls_reg;
  logic [9:0] line_reg;
  logic [8:0] col_reg;
  logic line_has_data_reg;
  logic in_frame_reg;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
      pck_prev_reg <= 1'b0;
    else
      pck_prev_reg <= pck_lvl_reg;
  end
  wire pck_rise = pck_lvl_reg && !pck_prev_reg;
  wire fs_fall = fs_reg && !fs_s_reg[2];
  wire ls_fall = ls_reg && !ls_s_reg[2];
  wire in_window = in_frame_reg && (line_reg < 10'(`RPT_ACTIVE_LINES)) &&
    (col_reg < 9'(`RPT_ACTIVE_PIXELS));
  wire take = pck_rise && pv_s_reg[2] && in_window && !blank_out;
  logic ff_ready;
  rpt_pkg::rpt_pixel_s wr_pix;
  assign wr_pix = '{line: line_reg, col: col_reg, rgb: rgb_s2_reg};
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      fs_reg <= 1'b1;
      ls_reg <= 1'b1;
      line_reg <= '0;
      col_reg <= '0;
      line_has_data_reg <= 1'b0;
      in_frame_reg <= 1'b0;
      overflow_out <= 1'b0;
    end
    else if (pck_rise)
    begin
      fs_reg <= fs_s_reg[2];
      ls_reg <= ls_s_reg[2];
      if (fs_fall)
      begin
        line_reg <= '0;
        in_frame_reg <= 1'b1;
        line_has_data_reg <= 1'b0;
      end
      else if (ls_fall)
      begin
        col_reg <= '0;
        line_has_data_reg <= 1'b0;
        if (line_has_data_reg && line_reg < 10'(`RPT_ACTIVE_LINES))
          line_reg <= line_reg + 10'h001;
      end
      else if (pv_s_reg[2])
      begin
        line_has_data_reg <= 1'b1;
        if (col_reg < 9'(`RPT_ACTIVE_PIXELS))
          col_reg <= col_reg + 9'h001;
      end
      overflow_out <= take && !ff_ready;
    end
  end
  rpt_fifo #(.WIDTH($bits(rpt_pkg::rpt_pixel_s)), .DEPTH(4)) u_fifo (
    .clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .wr_data_in(wr_pix),
    .wr_valid_in(take),
    .wr_ready_out(ff_ready),
    .rd_data_out(pix_out),
    .rd_valid_out(pix_valid_out),
    .rd_ready_in(pix_ready_in)
  );

  property p_short_reject;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (state_reg == rpt_pkg::RPT_IDLE) && low_cnt_reg < 32'(REJECT_CYC) |=>
      state_reg == rpt_pkg::RPT_IDLE;
  endproperty
  a_short_reject: assert property (p_short_reject) else $error("short reset accepted");
  property p_full_blank;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    (state_reg == rpt_pkg::RPT_PEND) && released && full_reg |=>
      state_reg == rpt_pkg::RPT_BLANK;
  endproperty
  a_full_blank: assert property (p_full_blank) else $error("long reset not taken");
  property p_blank_busy;
    @(posedge ref_clk_in) disable iff (!rstn_in) busy_out |-> blank_out;
  endproperty
  a_blank_busy: assert property (p_blank_busy) else $error("not blank in reset");
  property p_load_bound;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    state_reg == rpt_pkg::RPT_BLANK |-> seq_cnt_reg <= 32'(ID_LOAD_CYC);
  endproperty
  a_load_bound: assert property (p_load_bound) else $error("id load late");
  property p_id_load;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    state_reg == rpt_pkg::RPT_BLANK && state_next == rpt_pkg::RPT_LOAD |=>
      second_id_byte_out == $past(otp_id_in);
  endproperty
  a_id_load: assert property (p_id_load) else $error("id byte wrong");
  property p_complete;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    state_reg == rpt_pkg::RPT_LOAD |-> seq_cnt_reg <= 32'(COMPLETE_CYC);
  endproperty
  a_complete: assert property (p_complete) else $error("reset too long");
  property p_spike;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    state_reg == rpt_pkg::RPT_PEND && rst_lvl_reg && spike_ok |=>
      state_reg == rpt_pkg::RPT_PEND;
  endproperty
  a_spike: assert property (p_spike) else $error("spike aborted reset");
  property p_window;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    take |-> col_reg < 9'(`RPT_ACTIVE_PIXELS) && pv_s_reg[2] && !blank_out;
  endproperty
  a_window: assert property (p_window) else $error("pixel outside window");
  property p_count;
    @(posedge ref_clk_in) disable iff (!rstn_in)
    pck_rise && ls_fall && !fs_fall |=> col_reg == 9'h000;
  endproperty
  a_count: assert property (p_count) else $error("column not cleared");
  c_reset: cover property (@(posedge ref_clk_in) state_reg == rpt_pkg::RPT_LOAD);
  c_pixel: cover property (@(posedge ref_clk_in) take);
  c_spike: cover property (@(posedge ref_clk_in)
    state_reg == rpt_pkg::RPT_PEND && rst_lvl_reg);
endmodule // rpt_top
